// ==== inc/dsmux_pkg.sv ====
// Function
// - Regulator bit off pulls supply down, on releases pull-down.
// - Voltage bit selects 1.8 V when 0, 2.95 V when 1.
// - State 00 is powered down or totem pull-down, by regulator bit.
// - State 01 isolates with latched outputs; state 11 makes slot active.
// - State 10 is accepted, means powered with pull-downs; host avoids it.
// - Regulator bits never alter state bits, but shape reported status.
// - Debounce reloads are eight bits, reset 04h; 00h bypasses filtering.
// - Writing a reload while counting restarts within one timing tick.
// - Clock select bit 7 picks oscillator or external pin; 6:0 stored.
// - Direction enable clear means auto direction; set means pin decides.
// - Polarity bit inverts mapping of direction pin to transfer direction.
// - Battery interrupt enable sets status bit 3 and raises interrupt.
// - Battery threshold bit selects 1.2 V or 1.65 V comparator level.
// - Battery absent powers down both slots unless bit 4 is set.
// - Shutdown interrupt enable sets status bit 1 and raises interrupt.
// - Shutdown level bit selects which debounced level means shutdown.
// - Shutdown input powers down second slot only unless bit 7 set.
// - Bit 0 low enables pull-up; bit 1 high enables pull-down.
// - Reserved pull-select bits take writes and read as zero.
// - Interrupt pin level at reset picks address 78h/79h or 7Ah/7Bh.
// - Reset restores defaults, clears interrupts, slots off at 1.8 V.
// - Timing runs from the internal oscillator until external selected.
// - Debounce counts down on ticks while true, reloads on change.
// - Interrupt status bits clear when the status register is read.
package dsmux_pkg;
  localparam logic [7:0] ADDR_HW_REV = 8'h00;
  localparam logic [7:0] ADDR_SW_REV = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SLOT_CTL = 8'h08;
  localparam logic [7:0] ADDR_BSI_DB = 8'h0a;
  localparam logic [7:0] ADDR_SDN_DB = 8'h0b;
  localparam logic [7:0] ADDR_RSV_0C = 8'h0c;
  localparam logic [7:0] ADDR_CLK_SRC = 8'h0d;
  localparam logic [7:0] ADDR_DEV_CTL = 8'h0e;
  localparam logic [7:0] ADDR_PULL_SEL = 8'h15;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DEBOUNCE = 8'h04;
  localparam logic [7:0] SW_REV_VALUE = 8'h00;
  localparam logic [5:0] ADDR_BASE_HI = 6'h1e;
  // Slot control fields, per slot offset 4
  localparam int SLOT_STRIDE = 4;
  localparam int SLOT_REG_BIT = 0;
  localparam int SLOT_VSEL_BIT = 1;
  localparam int SLOT_STATE_LO = 2;
  // Device control fields
  localparam int DC_DIR_EN = 0;
  localparam int DC_DIR_POL = 1;
  localparam int DC_BSI_IE = 2;
  localparam int DC_BSI_LVL = 3;
  localparam int DC_BSI_NOAUTO = 4;
  localparam int DC_SDN_IE = 5;
  localparam int DC_SDN_LVL = 6;
  localparam int DC_SDN_NOAUTO = 7;
  localparam int CLK_SEL_BIT = 7;
  // Status fields
  localparam int ST_SDN_PIN = 0;
  localparam int ST_SDN_INT = 1;
  localparam int ST_BSI_ABS = 2;
  localparam int ST_BSI_INT = 3;
  // Slot interface codes
  localparam logic [1:0] SLOT_OFF = 2'b00;
  localparam logic [1:0] SLOT_ISOLATE = 2'b01;
  localparam logic [1:0] SLOT_POWERED = 2'b10;
  localparam logic [1:0] SLOT_ACTIVE = 2'b11;
  // Synchronised pin indices
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_IRQ = 2;
  localparam int PIN_BSI = 3;
  localparam int PIN_SDN = 4;
  localparam int PIN_DIR = 5;
  localparam int PIN_EXTCLK = 6;
  localparam int PIN_OSCTGL = 7;
  localparam int PIN_COUNT = 8;
  typedef enum logic [3:0] {
    I2C_IDLE = 4'b0000, I2C_ADDR = 4'b0001, I2C_ADDR_ACK = 4'b0011,
    I2C_PTR = 4'b0010, I2C_PTR_ACK = 4'b0110, I2C_WDATA = 4'b0111,
    I2C_WACK = 4'b0101, I2C_RDATA = 4'b0100, I2C_RACK = 4'b1100
  } dsmux_i2c_e;
endpackage

// ==== rtl/dsmux_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module dsmux_regs
  import dsmux_pkg::*;
#(
  parameter logic [7:0] HW_REV_VALUE = 8'h5a // Arbitrary identification value
)(
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Internal 32 kHz oscillator
  input wire logic clkOsc32,
  // Serial control bus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Interrupt pin, also address strap
  input wire logic irqIn,
  output logic irqOut,
  output logic irqOe,
  // Sense and control pins
  input wire logic batterySenseCompare,
  input wire logic slot2ShutdownInput,
  input wire logic dirPin,
  input wire logic extClkPin,
  // Slot controls, index 0 is slot one
  output logic [1:0] slotSupplyEn,
  output logic [1:0] slotSupplyPullDn,
  output logic [1:0] slotSel295,
  output logic [1:0] slotMode0,
  output logic [1:0] slotMode1,
  // Translator and sense controls
  output logic dirAuto,
  output logic dirCardToHost,
  output logic bsiThreshHigh,
  output logic sdnPullUpEn,
  output logic sdnPullDnEn
);
  // ********************************************
  // Pin synchronisers
  // ********************************************
  logic oscRstM, oscRst, oscTgl;
  logic [PIN_COUNT-1:0] pinM1, pinM2, pinM3, pinF, pinPrev, pinRaw;
  assign pinRaw = {oscTgl, extClkPin, dirPin, slot2ShutdownInput,
                   batterySenseCompare, irqIn, sdaIn, sclIn};
  always_ff @(posedge clkOsc32)
  begin
    oscRstM <= rst_n;
    oscRst <= oscRstM;
    if (!oscRst)
      oscTgl <= 1'b0;
    else
      oscTgl <= !oscTgl;
  end
  always_ff @(posedge clk_sys)
  begin
    pinM1 <= pinRaw;
    pinM2 <= pinM1;
    pinM3 <= pinM2;
    if (!rst_n)
    begin
      pinF <= pinM3;
      pinPrev <= pinM3;
    end
    else
    begin
      pinF <= (pinM2 & pinM3) | (pinF & (pinM2 ^ pinM3));
      pinPrev <= pinF;
    end
  end

  // ********************************************
  // Registers
  // ********************************************
  logic [7:0] slotCtl_r, bsiDb_r, sdnDb_r, rsv0c_r, clkSrc_r, devCtl_r;
  logic [1:0] pullSel_r;
  logic addrStrap_r, wrStb_r, stRd_r, bsiInt_r, sdnInt_r;
  logic [7:0] wrAddr_r, wrData_r;
  logic [1:0] dbDeb, dbRise, dbTrue;
  logic bsiAuto, sdnAuto;
  assign bsiAuto = dbRise[0] && !devCtl_r[DC_BSI_NOAUTO];
  assign sdnAuto = dbRise[1] && !devCtl_r[DC_SDN_NOAUTO];

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      addrStrap_r <= pinF[PIN_IRQ];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      slotCtl_r <= RST_ZERO;
      bsiDb_r <= RST_DEBOUNCE;
      sdnDb_r <= RST_DEBOUNCE;
      rsv0c_r <= RST_ZERO;
      clkSrc_r <= RST_ZERO;
      devCtl_r <= RST_ZERO;
      pullSel_r <= 2'b00;
    end
    else
    begin
      if (wrStb_r)
      begin
        case (wrAddr_r)
          ADDR_SLOT_CTL: slotCtl_r <= wrData_r;
          ADDR_BSI_DB: bsiDb_r <= wrData_r;
          ADDR_SDN_DB: sdnDb_r <= wrData_r;
          ADDR_RSV_0C: rsv0c_r <= wrData_r;
          ADDR_CLK_SRC: clkSrc_r <= wrData_r;
          ADDR_DEV_CTL: devCtl_r <= wrData_r;
          ADDR_PULL_SEL: pullSel_r <= wrData_r[1:0];
          default: ;
        endcase
      end
      // Automatic power-down overrides a same-cycle write
      if (bsiAuto)
      begin
        slotCtl_r[SLOT_REG_BIT] <= 1'b0;
        slotCtl_r[SLOT_STATE_LO+1:SLOT_STATE_LO] <= SLOT_OFF;
      end
      if (bsiAuto || sdnAuto)
      begin
        slotCtl_r[SLOT_STRIDE+SLOT_REG_BIT] <= 1'b0;
        slotCtl_r[SLOT_STRIDE+SLOT_STATE_LO+1:SLOT_STRIDE+SLOT_STATE_LO] <= SLOT_OFF;
      end
    end
  end

  // ********************************************
  // Timing tick and debounce
  // ********************************************
  logic tick;
  assign tick = clkSrc_r[CLK_SEL_BIT] ?
                (pinF[PIN_EXTCLK] && !pinPrev[PIN_EXTCLK]) :
                (pinF[PIN_OSCTGL] ^ pinPrev[PIN_OSCTGL]);
  assign dbTrue[0] = pinF[PIN_BSI];
  assign dbTrue[1] = pinF[PIN_SDN] == devCtl_r[DC_SDN_LVL];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_deb
      logic [7:0] cnt, reload;
      logic prevTrue, pend, debPrev, wrHit;
      assign reload = (gi == 0) ? bsiDb_r : sdnDb_r;
      assign wrHit = wrStb_r && (wrAddr_r == ((gi == 0) ? ADDR_BSI_DB : ADDR_SDN_DB));
      always_ff @(posedge clk_sys)
      begin
        if (!rst_n)
        begin
          cnt <= RST_DEBOUNCE;
          prevTrue <= 1'b0;
          pend <= 1'b0;
          dbDeb[gi] <= 1'b0;
          debPrev <= 1'b0;
        end
        else
        begin
          debPrev <= dbDeb[gi];
          pend <= wrHit || (pend && !tick);
          if (reload == RST_ZERO)
          begin
            cnt <= RST_ZERO;
            dbDeb[gi] <= dbTrue[gi];
          end
          else if (tick)
          begin
            prevTrue <= dbTrue[gi];
            if (!dbTrue[gi])
            begin
              cnt <= reload;
              dbDeb[gi] <= 1'b0;
            end
            else if (!prevTrue || (pend && !dbDeb[gi]))
              cnt <= reload;
            else if (cnt == RST_ZERO)
              dbDeb[gi] <= 1'b1;
            else
              cnt <= cnt - 8'h01;
          end
        end
      end
      assign dbRise[gi] = dbDeb[gi] && !debPrev;
    end
  endgenerate

  // ********************************************
  // Interrupts
  // ********************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      bsiInt_r <= 1'b0;
      sdnInt_r <= 1'b0;
      irqOe <= 1'b0;
    end
    else
    begin
      bsiInt_r <= (dbRise[0] && devCtl_r[DC_BSI_IE]) || (bsiInt_r && !stRd_r);
      sdnInt_r <= (dbRise[1] && devCtl_r[DC_SDN_IE]) || (sdnInt_r && !stRd_r);
      irqOe <= (bsiInt_r && devCtl_r[DC_BSI_IE]) || (sdnInt_r && devCtl_r[DC_SDN_IE]);
    end
  end
  assign irqOut = 1'b0;

  // ********************************************
  // Slot and translator outputs
  // ********************************************
  logic [1:0] slotStat [2];
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_slot
      logic en;
      logic [1:0] st;
      assign en = slotCtl_r[gi*SLOT_STRIDE+SLOT_REG_BIT];
      assign st = slotCtl_r[gi*SLOT_STRIDE+SLOT_STATE_LO +: 2];
      assign slotStat[gi] = !en ? SLOT_OFF :
                            (st == SLOT_OFF) ? SLOT_POWERED : st;
      always_ff @(posedge clk_sys)
      begin
        if (!rst_n)
        begin
          slotSupplyEn[gi] <= 1'b0;
          slotSupplyPullDn[gi] <= 1'b1;
          slotSel295[gi] <= 1'b0;
        end
        else
        begin
          slotSupplyEn[gi] <= en;
          slotSupplyPullDn[gi] <= !en;
          slotSel295[gi] <= slotCtl_r[gi*SLOT_STRIDE+SLOT_VSEL_BIT];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      slotMode0 <= SLOT_OFF;
      slotMode1 <= SLOT_OFF;
      dirAuto <= 1'b1;
      dirCardToHost <= 1'b0;
      bsiThreshHigh <= 1'b0;
      sdnPullUpEn <= 1'b1;
      sdnPullDnEn <= 1'b0;
    end
    else
    begin
      slotMode0 <= slotStat[0];
      slotMode1 <= slotStat[1];
      dirAuto <= !devCtl_r[DC_DIR_EN];
      dirCardToHost <= devCtl_r[DC_DIR_EN] &&
                       (pinF[PIN_DIR] ^ devCtl_r[DC_DIR_POL]);
      bsiThreshHigh <= devCtl_r[DC_BSI_LVL];
      sdnPullUpEn <= !pullSel_r[0];
      sdnPullDnEn <= pullSel_r[1];
    end
  end

  // ********************************************
  // Serial target
  // ********************************************
  function automatic logic [7:0] regRead(input logic [7:0] a);
    case (a)
      ADDR_HW_REV: regRead = HW_REV_VALUE;
      ADDR_SW_REV: regRead = SW_REV_VALUE;
      ADDR_STATUS: regRead = {slotStat[1], slotStat[0], bsiInt_r, dbDeb[0],
                              sdnInt_r, pinF[PIN_SDN]};
      ADDR_SLOT_CTL: regRead = slotCtl_r;
      ADDR_BSI_DB: regRead = bsiDb_r;
      ADDR_SDN_DB: regRead = sdnDb_r;
      ADDR_RSV_0C: regRead = rsv0c_r;
      ADDR_CLK_SRC: regRead = clkSrc_r;
      ADDR_DEV_CTL: regRead = devCtl_r;
      ADDR_PULL_SEL: regRead = {6'h00, pullSel_r};
      default: regRead = RST_ZERO;
    endcase
  endfunction

  dsmux_i2c_e state;
  logic [3:0] bitCnt;
  logic [7:0] shReg, txByte, ptr;
  logic rdMode, nack, sclRise, sclFall, startC, stopC;
  logic [7:0] rdByte;
  always_comb rdByte = regRead(ptr);
  assign sclRise = pinF[PIN_SCL] && !pinPrev[PIN_SCL];
  assign sclFall = !pinF[PIN_SCL] && pinPrev[PIN_SCL];
  assign startC = pinF[PIN_SCL] && pinPrev[PIN_SCL] && pinPrev[PIN_SDA] && !pinF[PIN_SDA];
  assign stopC = pinF[PIN_SCL] && pinPrev[PIN_SCL] && !pinPrev[PIN_SDA] && pinF[PIN_SDA];
  assign sdaOut = 1'b0;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state <= I2C_IDLE;
      bitCnt <= 4'h0;
      shReg <= RST_ZERO;
      txByte <= RST_ZERO;
      ptr <= RST_ZERO;
      rdMode <= 1'b0;
      nack <= 1'b0;
      sdaOe <= 1'b0;
      wrStb_r <= 1'b0;
      wrAddr_r <= RST_ZERO;
      wrData_r <= RST_ZERO;
      stRd_r <= 1'b0;
    end
    else
    begin
      wrStb_r <= 1'b0;
      stRd_r <= 1'b0;
      if (stopC)
      begin
        state <= I2C_IDLE;
        sdaOe <= 1'b0;
      end
      else if (startC)
      begin
        state <= I2C_ADDR;
        bitCnt <= 4'h0;
        sdaOe <= 1'b0;
      end
      else if (sclRise)
      begin
        if (state == I2C_RACK)
          nack <= pinF[PIN_SDA];
        else
        begin
          shReg <= {shReg[6:0], pinF[PIN_SDA]};
          bitCnt <= bitCnt + 4'h1;
        end
      end
      else if (sclFall)
      begin
        case (state)
          I2C_ADDR:
            if (bitCnt == 4'h8)
            begin
              if (shReg[7:1] == {ADDR_BASE_HI, addrStrap_r})
              begin
                sdaOe <= 1'b1;
                rdMode <= shReg[0];
                state <= I2C_ADDR_ACK;
              end
              else
                state <= I2C_IDLE;
            end
          I2C_PTR, I2C_WDATA:
            if (bitCnt == 4'h8)
            begin
              sdaOe <= 1'b1;
              if (state == I2C_PTR)
              begin
                ptr <= shReg;
                state <= I2C_PTR_ACK;
              end
              else
              begin
                wrStb_r <= 1'b1;
                wrAddr_r <= ptr;
                wrData_r <= shReg;
                ptr <= ptr + 8'h01;
                state <= I2C_WACK;
              end
            end
          I2C_PTR_ACK, I2C_WACK:
          begin
            sdaOe <= 1'b0;
            bitCnt <= 4'h0;
            state <= I2C_WDATA;
          end
          I2C_ADDR_ACK, I2C_RACK:
          begin
            bitCnt <= 4'h0;
            if (state == I2C_ADDR_ACK && !rdMode)
            begin
              sdaOe <= 1'b0;
              state <= I2C_PTR;
            end
            else if (state == I2C_RACK && nack)
            begin
              sdaOe <= 1'b0;
              state <= I2C_IDLE;
            end
            else
            begin
              txByte <= rdByte;
              sdaOe <= !rdByte[7];
              stRd_r <= (ptr == ADDR_STATUS);
              ptr <= ptr + 8'h01;
              state <= I2C_RDATA;
            end
          end
          I2C_RDATA:
            if (bitCnt == 4'h8)
            begin
              sdaOe <= 1'b0;
              state <= I2C_RACK;
            end
            else
              sdaOe <= !txByte[3'(4'h7 - bitCnt)];
          default: state <= I2C_IDLE;
        endcase
      end
    end
  end

  // ********************************************
  // Assertions
  // ********************************************
  property p_reg_follow;
    @(posedge clk_sys) disable iff (!rst_n)
    wrStb_r && wrAddr_r == ADDR_SLOT_CTL && !bsiAuto
    |=> ##1 slotSupplyEn[0] == $past(wrData_r[0], 2);
  endproperty
  a_reg_follow: assert property (p_reg_follow) else $error("slot one supply not following write");
  property p_vsel;
    @(posedge clk_sys) disable iff (!rst_n)
    wrStb_r && wrAddr_r == ADDR_SLOT_CTL |=> ##1 slotSel295[1] == $past(wrData_r[5], 2);
  endproperty
  a_vsel: assert property (p_vsel) else $error("slot two voltage select wrong");
  property p_active;
    @(posedge clk_sys) disable iff (!rst_n)
    slotCtl_r[3:0] == 4'hd |=> slotMode0 == SLOT_ACTIVE;
  endproperty
  a_active: assert property (p_active) else $error("slot one not active");
  property p_off_status;
    @(posedge clk_sys) disable iff (!rst_n)
    !slotCtl_r[4] |=> slotMode1 == SLOT_OFF && slotSupplyPullDn[1];
  endproperty
  a_off_status: assert property (p_off_status) else $error("slot two status not off");
  property p_bsi_int;
    @(posedge clk_sys) disable iff (!rst_n)
    dbRise[0] && devCtl_r[DC_BSI_IE] |=> bsiInt_r ##1 irqOe;
  endproperty
  a_bsi_int: assert property (p_bsi_int) else $error("battery interrupt missing");
  property p_auto_both;
    @(posedge clk_sys) disable iff (!rst_n)
    bsiAuto |=> !slotCtl_r[0] && !slotCtl_r[4];
  endproperty
  a_auto_both: assert property (p_auto_both) else $error("battery power-down missed");
  property p_auto_slot2;
    @(posedge clk_sys) disable iff (!rst_n)
    sdnAuto && !bsiAuto && !wrStb_r |=> !slotCtl_r[4] && $stable(slotCtl_r[3:0]);
  endproperty
  a_auto_slot2: assert property (p_auto_slot2) else $error("shutdown touched wrong slot");
  property p_rd_clear;
    @(posedge clk_sys) disable iff (!rst_n)
    stRd_r && !dbRise[1] |=> !sdnInt_r ##1 (!irqOe || bsiInt_r);
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("status read did not clear");
  property p_no_int;
    @(posedge clk_sys) disable iff (!rst_n)
    !devCtl_r[DC_SDN_IE] && !devCtl_r[DC_BSI_IE] [*2] |-> !irqOe;
  endproperty
  a_no_int: assert property (p_no_int) else $error("interrupt while disabled");
  property p_bypass;
    @(posedge clk_sys) disable iff (!rst_n)
    sdnDb_r == RST_ZERO && $stable(sdnDb_r) |=> dbDeb[1] == $past(dbTrue[1]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("debounce bypass failed");
endmodule
`default_nettype wire

// ==== testbench/dsmux_i2c_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// Serial host model
// ****
module dsmux_i2c_host (
  // Clock
  input wire logic clk_sys,
  // Bus lines
  input wire logic sdaLine,
  output logic sclOut,
  output logic sdaLow
);
  localparam int HALF = 20;
  initial
  begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic bitCyc(input logic low, output logic seen);
    @(posedge clk_sys) sclOut <= 1'b0;
    repeat (5) @(posedge clk_sys);
    sdaLow <= low;
    repeat (HALF - 5) @(posedge clk_sys);
    sclOut <= 1'b1;
    repeat (HALF) @(posedge clk_sys);
    seen = sdaLine;
  endtask
  task automatic sdaSet(input logic low);
    sdaLow <= low;
    repeat (HALF) @(posedge clk_sys);
  endtask
  task automatic startC;
    logic s;
    bitCyc(1'b0, s);
    sdaSet(1'b1);
  endtask
  task automatic stopC;
    logic s;
    bitCyc(1'b1, s);
    sdaSet(1'b0);
  endtask
  task automatic xByte(input logic [7:0] tx, input logic ackMe, output logic [7:0] rx,
                       output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitCyc(~tx[i], rx[i]);
    bitCyc(ackMe, s);
    ack = ~s;
  endtask
  task automatic wrReg(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] d,
                       output logic ok);
    logic [7:0] r;
    logic k0;
    logic k1;
    logic k2;
    k1 = 1'b0;
    k2 = 1'b0;
    startC();
    xByte(dev, 1'b0, r, k0);
    if (k0)
    begin
      xByte(a, 1'b0, r, k1);
      xByte(d, 1'b0, r, k2);
    end
    stopC();
    ok = k0 & k1 & k2;
  endtask
  task automatic rdRegs(input logic [7:0] dev, input logic [7:0] ptr, input int n,
                        output logic [7:0] q [8], output logic ok);
    logic [7:0] r;
    logic k0;
    logic k1;
    logic k2;
    logic k;
    startC();
    xByte(dev, 1'b0, r, k0);
    xByte(ptr, 1'b0, r, k1);
    startC();
    xByte(dev | 8'h01, 1'b0, r, k2);
    for (int i = 0; i < n; i++)
      xByte(8'hff, i < n - 1, q[i], k);
    stopC();
    ok = k0 & k1 & k2;
  endtask
endmodule
`default_nettype wire

// ==== testbench/dsmux_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((ex) !== (gt)) begin err_count++; \
  $display("FAIL %s expected %h seen %h", nm, ex, gt); end end
module dsmux_regs_tb
  import dsmux_pkg::*;
;
  // ****
  // Bench signals
  // ****
  localparam logic [7:0] DEV = 8'h7a;
  localparam logic [7:0] HW_REV = 8'h5a; // Arbitrary identification value
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic clkOsc32 = 1'b0;
  logic extClkPin = 1'b0;
  logic battery_sense_input = 1'b0;
  logic sdnPin = 1'b1;
  logic dirPin = 1'b0;
  logic sclHost, sdaLow, sdaOe, irqOe, dirAuto, dirC2h, thrHi, puEn, pdEn;
  logic [1:0] supEn, supPd, sel295, mode0, mode1;
  wire logic sdaLine;
  wire logic irqLine;
  logic [7:0] mdl [256];
  logic [7:0] tbl [8] = '{8'h08, 8'h0a, 8'h0b, 8'h0d, 8'h0e, 8'h15, 8'h00, 8'h30};
  logic [7:0] up [4] = '{8'h00, 8'h01, 8'h0d, 8'hdd};
  logic bsiInt, sdnInt, bsiAbs, ok;
  logic [7:0] d;
  integer seed = 35;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int extDiv = 0;
  int n;
  assign sdaLine = ~(sdaOe | sdaLow);
  assign irqLine = ~irqOe;
  always #2 clk_sys = ~clk_sys;
  initial
  begin
    #5.3;
    forever #24 clkOsc32 = ~clkOsc32;
  end
  always @(posedge clk_sys)
  begin
    extDiv <= (extDiv == 199) ? 0 : extDiv + 1;
    if (extDiv == 199)
      extClkPin <= ~extClkPin;
    cycles <= cycles + 1;
    if (cycles == 92000)
    begin
      err_count++;
      wrap_up();
    end
  end
  dsmux_regs #(.HW_REV_VALUE(HW_REV)) i_dsmux_regs (.clk_sys(clk_sys), .rst_n(rst_n),
    .clkOsc32(clkOsc32), .sclIn(sclHost), .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOe),
    .irqIn(irqLine), .irqOut(), .irqOe(irqOe), .batterySenseCompare(battery_sense_input),
    .slot2ShutdownInput(sdnPin), .dirPin(dirPin), .extClkPin(extClkPin),
    .slotSupplyEn(supEn), .slotSupplyPullDn(supPd), .slotSel295(sel295),
    .slotMode0(mode0), .slotMode1(mode1), .dirAuto(dirAuto), .dirCardToHost(dirC2h),
    .bsiThreshHigh(thrHi), .sdnPullUpEn(puEn), .sdnPullDnEn(pdEn));
  dsmux_i2c_host i_dsmux_i2c_host (.clk_sys(clk_sys), .sdaLine(sdaLine), .sclOut(sclHost),
    .sdaLow(sdaLow));
  // ****
  // Reference model
  // ****
  function automatic logic [1:0] stCode(input logic [7:0] c, input int s);
    if (!c[4 * s])
      return 2'b00;
    return (c[4 * s + 2 +: 2] == 2'b00) ? 2'b10 : c[4 * s + 2 +: 2];
  endfunction
  function automatic logic [7:0] expRd(input logic [7:0] a);
    if (a == 8'h04)
      return {stCode(mdl[8], 1), stCode(mdl[8], 0), bsiInt, bsiAbs, sdnInt, sdnPin};
    return mdl[a];
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_dsmux_i2c_host.wrReg(DEV, a, v, ok);
    `CHK("ack", 1'b1, ok)
    case (a)
      8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e: mdl[a] = v;
      8'h15: mdl[a] = v & 8'h03;
      default: ;
    endcase
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic rdChk(input logic [7:0] p, input int cnt);
    logic [7:0] q [8];
    i_dsmux_i2c_host.rdRegs(DEV, p, cnt, q, ok);
    `CHK("rdack", 1'b1, ok)
    for (int i = 0; i < cnt; i++)
    begin
      `CHK("rd", expRd(p + 8'(i)), q[i])
      if (p + 8'(i) == 8'h04)
      begin
        bsiInt = 1'b0;
        sdnInt = 1'b0;
      end
    end
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic checkOuts;
    logic [7:0] c;
    logic [7:0] v;
    c = mdl[8'h08];
    v = mdl[8'h0e];
    `CHK("supEn", {c[4], c[0]}, supEn)
    `CHK("supPd", ~{c[4], c[0]}, supPd)
    `CHK("sel", {c[5], c[1]}, sel295)
    `CHK("mode", {stCode(c, 1), stCode(c, 0)}, {mode1, mode0})
    `CHK("auto", ~v[0], dirAuto)
    if (v[0])
      `CHK("dir", dirPin ^ v[1], dirC2h)
    `CHK("thr", v[3], thrHi)
    `CHK("pu", ~mdl[8'h15][0], puEn)
    `CHK("pd", mdl[8'h15][1], pdEn)
    `CHK("irq", bsiInt | sdnInt, irqOe)
  endtask
  task automatic doReset;
    @(posedge clk_sys) rst_n <= 1'b0;
    repeat (40) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    foreach (mdl[i])
      mdl[i] = 8'h00;
    mdl[8'h00] = HW_REV;
    mdl[8'h0a] = 8'h04;
    mdl[8'h0b] = 8'h04;
    bsiInt = 1'b0;
    sdnInt = 1'b0;
    bsiAbs = 1'b0;
  endtask
  task automatic waitIrq(input int lim);
    n = 0;
    while (irqOe !== 1'b1 && n < lim)
    begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  initial
  begin
    doReset();
    checkOuts();
    rdChk(8'h00, 8);
    rdChk(8'h08, 8);
    rdChk(8'h15, 1);
    i_dsmux_i2c_host.wrReg(8'h78, 8'h08, 8'hff, ok);
    `CHK("nack", 1'b0, ok)
    for (int r = 0; r < 3; r++)
      for (int i = 0; i < 8; i++)
      begin
        @(posedge clk_sys) dirPin <= 1'($random(seed));
        d = 8'($random(seed));
        if (tbl[i] == 8'h0e)
          d[6] = 1'b0;
        wr(tbl[i], d);
        checkOuts();
      end
    rdChk(8'h08, 8);
    rdChk(8'h15, 1);
    rdChk(8'h30, 1);
    wr(8'h0e, 8'h04);
    wr(8'h0d, 8'h80);
    wr(8'h08, 8'hdd);
    wr(8'h0a, 8'h04);
    @(posedge clk_sys) battery_sense_input <= 1'b1;
    wr(8'h0a, 8'h07);
    repeat (6) @(posedge extClkPin);
    `CHK("early", 1'b0, irqOe)
    waitIrq(4000);
    bsiInt = 1'b1;
    bsiAbs = 1'b1;
    mdl[8'h08] &= 8'h22;
    repeat (3) @(posedge clk_sys);
    checkOuts();
    rdChk(8'h04, 1);
    checkOuts();
    rdChk(8'h04, 1);
    @(posedge clk_sys) battery_sense_input <= 1'b0;
    repeat (3) @(posedge extClkPin);
    bsiAbs = 1'b0;
    wr(8'h0e, 8'h30);
    wr(8'h0b, 8'h00);
    foreach (up[i])
      wr(8'h08, up[i]);
    @(posedge clk_sys) sdnPin <= 1'b0;
    waitIrq(60);
    sdnInt = 1'b1;
    mdl[8'h08] &= 8'h2f;
    repeat (3) @(posedge clk_sys);
    checkOuts();
    rdChk(8'h04, 1);
    checkOuts();
    @(posedge clk_sys) sdnPin <= 1'b1;
    doReset();
    checkOuts();
    rdChk(8'h08, 8);
    wrap_up();
  end
endmodule
`default_nettype wire
